// ==== mcdg_pkg.sv ====
// Constants and carrier types for the main clock divider and gating unit
package mcdg_pkg;

    // Wishbone byte address width; the word index is adr[7:2]
    localparam int MCDG_ADR_W = 8;
    localparam int MCDG_IDX_W = 6;

    // Register indexes; byte address is four times the index
    localparam logic [5:0] IDX_PRIMARY_CONTROL = 6'h00;
    localparam logic [5:0] IDX_IRQ_ENABLE_CLEAR = 6'h01;
    localparam logic [5:0] IDX_IRQ_ENABLE_SET = 6'h02;
    localparam logic [5:0] IDX_IRQ_FLAG_STATUS = 6'h03;
    localparam logic [5:0] IDX_CPU_DOMAIN_DIVIDER = 6'h04;
    localparam logic [5:0] IDX_LOWPOWER_DOMAIN_DIVIDER = 6'h05;
    localparam logic [5:0] IDX_BACKUP_DOMAIN_DIVIDER = 6'h06;

    // Gate masks: 0 system bus, 1..5 bridges a..e
    localparam int MASK_NUM = 6;
    localparam logic [MASK_NUM-1:0][5:0] MASK_IDX = {
        6'h24, 6'h20, 6'h1c, 6'h18, 6'h14, 6'h10
    };
    localparam logic [MASK_NUM-1:0][31:0] MASK_RST = {
        32'h0000_0001, 32'h0000_00ff, 32'h0000_7fff,
        32'h0000_0017, 32'h0000_1fff, 32'h000f_ffff
    };
    localparam logic [MASK_NUM-1:0][31:0] MASK_WR = {
        32'h0000_0001, 32'h0000_007f, 32'h0000_007f,
        32'h0000_0007, 32'h0000_007f, 32'h0000_193f
    };

    // Clock domain of each gate mask
    localparam logic [1:0] DOM_CPU = 2'h0;
    localparam logic [1:0] DOM_LP = 2'h1;
    localparam logic [1:0] DOM_BUP = 2'h2;
    localparam logic [MASK_NUM-1:0][1:0] MASK_DOM = {
        DOM_LP, DOM_LP, DOM_LP, DOM_CPU, DOM_BUP, DOM_CPU
    };

    // Field positions and reset values
    localparam int CLOCK_READY_FLAG_BIT = 0;
    localparam logic [7:0] DIV_RST = 8'h01;
    localparam logic FLAG_RST = 1'b1;
    localparam logic IEN_RST = 1'b0;
    localparam int PRESC_W = 7;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [MCDG_ADR_W-1:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } mcdg_wb_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } mcdg_wb_rsp_t;

    typedef struct packed {
        logic cpu;
        logic lp;
        logic bup;
    } mcdg_tick_t;

    typedef struct packed {
        mcdg_wb_rsp_t wb;
        logic ien;
        logic flag;
        logic irq;
        logic [7:0] cpu_div;
        logic [7:0] lp_div;
        logic [7:0] bup_div;
        logic [7:0] cpu_act;
        logic [7:0] lp_act;
        logic [7:0] bup_act;
        logic pend;
        logic viol;
        logic frozen;
        logic [PRESC_W-1:0] cnt;
        mcdg_tick_t tick;
        logic [MASK_NUM-1:0][31:0] mask;
        logic [MASK_NUM-1:0][31:0] gate;
    } mcdg_state_t;

endpackage : mcdg_pkg

// ==== mcdg_main_clock.sv ====
// Main clock prescaler, domain dividers, clock-ready flag and gate masks
//
// The Wishbone register port was decided locally.
`timescale 1ns/10ps
`default_nettype none
module mcdg_main_clock
    import mcdg_pkg::*;
#(
    parameter int ADR_W = mcdg_pkg::MCDG_ADR_W
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Wishbone slave
    input wire mcdg_pkg::mcdg_wb_req_t wb_req_i,
    output var mcdg_pkg::mcdg_wb_rsp_t wb_rsp_o,
    // Sleep controller
    input wire logic standby_sleep_i,
    input wire logic clock_request_i,
    // Derived clock enables and gates
    output var mcdg_pkg::mcdg_tick_t domain_tick_o,
    output logic [mcdg_pkg::MASK_NUM-1:0][31:0] module_gate_o,
    // Interrupt and access guard
    output logic irq_o,
    output logic access_guard_violation_o
);
    import mcdg_pkg::*;

    if (ADR_W != MCDG_ADR_W) begin : g_chk
        $error("mcdg_main_clock: ADR_W must equal MCDG_ADR_W");
    end

    mcdg_state_t st;
    mcdg_state_t next_st;

    logic access;
    logic wr;
    logic [MCDG_IDX_W-1:0] idx;
    logic [31:0] be;
    logic [31:0] mword;
    logic [7:0] div_mask;
    logic apply;
    logic div_wr;
    logic bad_code;
    logic [31:0] rdat;

    always_comb begin
        next_st = st;
        mword = 32'h0000_0000;
        div_mask = 8'h00;
        rdat = 32'h0000_0000;
        // Classic handshake: answer one cycle after the strobe
        access = wb_req_i.cyc & wb_req_i.stb & ~st.wb.ack;
        wr = access & wb_req_i.we;
        idx = wb_req_i.adr[ADR_W-1:2];
        be = {{8{wb_req_i.sel[3]}}, {8{wb_req_i.sel[2]}},
              {8{wb_req_i.sel[1]}}, {8{wb_req_i.sel[0]}}};
        next_st.wb.ack = access;
        next_st.viol = 1'b0;

        // Read multiplexer, unmapped words read zero
        unique case (idx)
            IDX_PRIMARY_CONTROL: rdat = 32'h0000_0000;
            IDX_IRQ_ENABLE_CLEAR,
            IDX_IRQ_ENABLE_SET: rdat[CLOCK_READY_FLAG_BIT] = st.ien;
            IDX_IRQ_FLAG_STATUS: rdat[CLOCK_READY_FLAG_BIT] = st.flag;
            IDX_CPU_DOMAIN_DIVIDER: rdat[7:0] = st.cpu_div;
            IDX_LOWPOWER_DOMAIN_DIVIDER: rdat[7:0] = st.lp_div;
            IDX_BACKUP_DOMAIN_DIVIDER: rdat[7:0] = st.bup_div;
            default: rdat = 32'h0000_0000;
        endcase
        for (int i = 0; i < MASK_NUM; i++) begin
            if (idx == MASK_IDX[i]) begin
                rdat = st.mask[i];
            end
        end
        next_st.wb.dat = access ? (rdat & be) : 32'h0000_0000;

        // Interrupt enable, single shared state
        if (wr && wb_req_i.sel[0] && wb_req_i.dat[CLOCK_READY_FLAG_BIT]) begin
            if (idx == IDX_IRQ_ENABLE_SET) begin
                next_st.ien = 1'b1;
            end
            if (idx == IDX_IRQ_ENABLE_CLEAR) begin
                next_st.ien = 1'b0;
            end
        end

        // Divider registers store whatever is written
        div_wr = 1'b0;
        bad_code = 1'b0;
        if (wr && wb_req_i.sel[0]) begin
            if (idx == IDX_CPU_DOMAIN_DIVIDER) begin
                next_st.cpu_div = wb_req_i.dat[7:0];
                div_wr = 1'b1;
                bad_code = !$onehot(wb_req_i.dat[7:0]);
            end
            if (idx == IDX_LOWPOWER_DOMAIN_DIVIDER) begin
                next_st.lp_div = wb_req_i.dat[7:0];
                div_wr = 1'b1;
                bad_code = !$onehot(wb_req_i.dat[7:0]);
            end
            if (idx == IDX_BACKUP_DOMAIN_DIVIDER) begin
                next_st.bup_div = wb_req_i.dat[7:0];
                div_wr = 1'b1;
            end
        end

        // Gate masks: read-only bits hold their reset values
        for (int i = 0; i < MASK_NUM; i++) begin
            if (wr && idx == MASK_IDX[i]) begin
                mword = (st.mask[i] & ~be) | (wb_req_i.dat & be);
                next_st.mask[i] = (mword & MASK_WR[i])
                    | (MASK_RST[i] & ~MASK_WR[i]);
            end
        end

        // Freeze only in standby with no clock requested
        next_st.frozen = standby_sleep_i & ~clock_request_i;
        if (!st.frozen) begin
            next_st.cnt = st.cnt + PRESC_W'(1);
        end

        // Apply pending ratios when every divider is aligned
        apply = st.pend & ~st.frozen & (st.cnt == '0);
        if (wr && wb_req_i.sel[0] && idx == IDX_IRQ_FLAG_STATUS
                && wb_req_i.dat[CLOCK_READY_FLAG_BIT]) begin
            next_st.flag = 1'b0;
        end
        if (apply) begin
            // Reserved codes are kept but not used
            if ($onehot(st.cpu_div)) begin
                next_st.cpu_act = st.cpu_div;
            end
            if ($onehot(st.lp_div)) begin
                next_st.lp_act = st.lp_div;
            end
            if ($onehot(st.bup_div)) begin
                next_st.bup_act = st.bup_div;
            end
            next_st.pend = 1'b0;
            next_st.flag = 1'b1;
        end
        if (div_wr) begin
            // New setting pending: flag reads zero until applied
            next_st.pend = 1'b1;
            next_st.flag = 1'b0;
            next_st.viol = bad_code | ~st.flag;
        end

        next_st.irq = next_st.flag & next_st.ien;

        // Domain ticks at the applied ratios
        div_mask = st.cpu_act - 8'h01;
        next_st.tick.cpu = ~st.frozen & ((st.cnt & div_mask[PRESC_W-1:0]) == '0);
        div_mask = st.lp_act - 8'h01;
        next_st.tick.lp = ~st.frozen & ((st.cnt & div_mask[PRESC_W-1:0]) == '0);
        div_mask = st.bup_act - 8'h01;
        next_st.tick.bup = ~st.frozen & ((st.cnt & div_mask[PRESC_W-1:0]) == '0);

        // Registered per-module enables change only at rising edges,
        // so the downstream gate cell sees them stable in the low phase
        for (int i = 0; i < MASK_NUM; i++) begin
            unique case (MASK_DOM[i])
                DOM_CPU: next_st.gate[i] = st.mask[i] & {32{next_st.tick.cpu}};
                DOM_LP: next_st.gate[i] = st.mask[i] & {32{next_st.tick.lp}};
                default: next_st.gate[i] = st.mask[i] & {32{next_st.tick.bup}};
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= '0;
            st.ien <= IEN_RST;
            st.flag <= FLAG_RST;
            st.cpu_div <= DIV_RST;
            st.lp_div <= DIV_RST;
            st.bup_div <= DIV_RST;
            st.cpu_act <= DIV_RST;
            st.lp_act <= DIV_RST;
            st.bup_act <= DIV_RST;
            st.mask <= MASK_RST;
        end else begin
            st <= next_st;
        end
    end

    assign wb_rsp_o = st.wb;
    assign domain_tick_o = st.tick;
    assign module_gate_o = st.gate;
    assign irq_o = st.irq;
    assign access_guard_violation_o = st.viol;

endmodule : mcdg_main_clock
`default_nettype wire

// ==== mcdg_main_clock_assertions.sv ====
// Bus and clock output checks for the main clock unit
`timescale 1ns/10ps
`default_nettype none
module mcdg_main_clock_chk
    import mcdg_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Bus
    input wire mcdg_pkg::mcdg_wb_req_t wb_req_i,
    input wire mcdg_pkg::mcdg_wb_rsp_t wb_rsp_o,
    // Sleep and outputs
    input wire logic standby_sleep_i,
    input wire logic clock_request_i,
    input wire mcdg_pkg::mcdg_tick_t domain_tick_o,
    input wire logic [mcdg_pkg::MASK_NUM-1:0][31:0] module_gate_o,
    input wire logic irq_o,
    input wire logic access_guard_violation_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    a_ack_one_cycle: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
        else $error("ack held too long");
    a_ack_answers: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack
        |=> wb_rsp_o.ack) else $error("request not answered");
    a_dat_idle_zero: assert property (!wb_rsp_o.ack |-> wb_rsp_o.dat == 32'h0)
        else $error("read data outside ack");
    a_ctrl_reads_zero: assert property (wb_rsp_o.ack && !wb_req_i.we
        && wb_req_i.adr[7:2] == IDX_PRIMARY_CONTROL |-> wb_rsp_o.dat == 32'h0)
        else $error("control reads nonzero");
    a_clear_drops_irq: assert property (wb_rsp_o.ack && wb_req_i.we
        && wb_req_i.adr == 8'h04 && wb_req_i.sel[0] && wb_req_i.dat[0] |=> !irq_o)
        else $error("irq survives enable clear");
    a_viol_pulse: assert property (access_guard_violation_o
        |=> !access_guard_violation_o) else $error("violation longer than a pulse");
    a_viol_with_ack: assert property (access_guard_violation_o
        |-> wb_rsp_o.ack && wb_req_i.we) else $error("violation without a write");
    a_frozen_ticks: assert property ((standby_sleep_i && !clock_request_i) [*4]
        |-> domain_tick_o == 3'h0) else $error("ticks while frozen");
    a_gate_needs_tick: assert property (!domain_tick_o.cpu
        |-> module_gate_o[0] == 32'h0 && module_gate_o[2] == 32'h0)
        else $error("gate open without tick");
    a_guard_bits_on: assert property (domain_tick_o.cpu
        |-> (module_gate_o[0] & 32'h000fe6c0) == 32'h000fe6c0)
        else $error("read-only gate bit low");
endmodule : mcdg_main_clock_chk
bind mcdg_main_clock mcdg_main_clock_chk u_chk (.clk_i, .rst_n_i, .wb_req_i, .wb_rsp_o,
    .standby_sleep_i, .clock_request_i, .domain_tick_o, .module_gate_o, .irq_o,
    .access_guard_violation_o);
`default_nettype wire

// ==== test_main_clock_divider_gating.sv ====
// Register and clock output test for the main clock unit
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
module test_main_clock_divider_gating;
    import mcdg_pkg::*;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic standby_sleep_i = 1'b0;
    logic clock_request_i = 1'b0;
    mcdg_wb_req_t req = '0;
    mcdg_wb_rsp_t rsp;
    mcdg_tick_t tick;
    logic [MASK_NUM-1:0][31:0] gate;
    logic irq;
    logic viol;
    logic [31:0] rd;
    logic [7:0] ra [14] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h40,
        8'h50, 8'h60, 8'h70, 8'h80, 8'h90, 8'h1c};
    logic [31:0] ev [8] = '{0, 0, 0, 1, 1, 1, 1, 32'h000fffff};
    int miscompares = 0;
    int total_checks = 0;
    int viols = 0;
    int cycles = 0;
    int p;
    always #5 clk_i = ~clk_i;
    mcdg_main_clock u_dut (.clk_i, .rst_n_i, .wb_req_i(req), .wb_rsp_o(rsp),
        .standby_sleep_i, .clock_request_i, .domain_tick_o(tick), .module_gate_o(gate),
        .irq_o(irq), .access_guard_violation_o(viol));
    always @(posedge clk_i) begin
        cycles++;
        if (viol === 1'b1) viols++;
        if (cycles == 20000) begin
            miscompares++;
            end_sim();
        end
    end
    task automatic end_sim();
        if (miscompares == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_sim
    task automatic xfer(input logic we, input logic [7:0] a, input logic [3:0] s,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        req <= '{1'b1, 1'b1, we, a, s, d};
        do begin @(posedge clk_i); n++; end while (rsp.ack !== 1'b1 && n < 50);
        if (n == 50) miscompares++;
        rd = rsp.dat;
        req.cyc <= 1'b0;
        req.stb <= 1'b0;
    endtask : xfer
    task automatic ready();
        int n;
        n = 0;
        do begin xfer(0, 8'h0c, 4'h1, 0); n++; end while (rd[0] !== 1'b1 && n < 100);
        `CHK("ready", 1'b1, rd[0])
    endtask : ready
    // Cycles from one domain tick to the next
    task automatic period(input int d);
        p = 0;
        while (tick[2-d] !== 1'b1 && p < 300) begin @(posedge clk_i); p++; end
        p = 0;
        do begin @(posedge clk_i); p++; end while (tick[2-d] !== 1'b1 && p < 300);
    endtask : period
    initial begin
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        for (int i = 0; i < 14; i++) begin
            xfer(0, ra[i], 4'hf, 0);
            `CHK("reset_value", (i >= 8 && i < 13) ? MASK_RST[i-7] : (i < 8 ? ev[i] : 0), rd)
        end
        xfer(1, 8'h1c, 4'hf, '1);
        xfer(0, 8'h1c, 4'hf, 0);
        `CHK("unmapped", 32'h0, rd)
        xfer(1, 8'h00, 4'hf, '1);
        xfer(0, 8'h00, 4'hf, 0);
        `CHK("primary_control", 32'h0, rd)
        xfer(1, 8'h08, 4'h1, 0);
        xfer(0, 8'h04, 4'h1, 0);
        `CHK("enable_idle", 32'h0, rd)
        xfer(1, 8'h08, 4'h1, 1);
        xfer(0, 8'h04, 4'h1, 0);
        `CHK("enable_shared", 32'h1, rd)
        `CHK("irq_on", 1'b1, irq)
        xfer(1, 8'h04, 4'h1, 0);
        xfer(0, 8'h08, 4'h1, 0);
        `CHK("clear_zero", 32'h1, rd)
        xfer(1, 8'h04, 4'h1, 1);
        xfer(0, 8'h08, 4'h1, 0);
        `CHK("clear_one", 32'h0, rd)
        `CHK("irq_off", 1'b0, irq)
        xfer(1, 8'h08, 4'h1, 1);
        xfer(1, 8'h18, 4'h1, 8'h80);
        ready();
        xfer(1, 8'h14, 4'h1, 8'h80);
        ready();
        for (int k = 0; k < 8; k++) begin
            xfer(1, 8'h10, 4'h1, 32'h1 << k);
            ready();
            `CHK("irq_ready", 1'b1, irq)
            period(0);
            `CHK("cpu_period", 1 << k, p)
        end
        period(1);
        `CHK("lp_period", 128, p)
        period(2);
        `CHK("bup_period", 128, p)
        xfer(1, 8'h10, 4'h2, '1);
        xfer(0, 8'h10, 4'h1, 0);
        `CHK("lane_ignored", 32'h80, rd)
        xfer(1, 8'h0c, 4'h1, 0);
        xfer(0, 8'h0c, 4'h1, 0);
        `CHK("flag_keep", 32'h1, rd)
        xfer(1, 8'h0c, 4'h1, 1);
        xfer(0, 8'h0c, 4'h1, 0);
        `CHK("flag_clear", 32'h0, rd)
        `CHK("irq_cleared", 1'b0, irq)
        p = viols;
        xfer(1, 8'h10, 4'h1, 8'h03);
        xfer(0, 8'h10, 4'h1, 0);
        `CHK("bad_code", 32'h3, rd)
        `CHK("violations", p + 1, viols)
        period(0);
        `CHK("bad_not_used", 128, p)
        xfer(1, 8'h40, 4'hf, 32'h000fe6c0);
        xfer(0, 8'h40, 4'hf, 0);
        `CHK("mask_ro", 32'h000fe6c0, rd)
        period(0);
        `CHK("gate_sys", 32'h000fe6c0, gate[0])
        xfer(1, 8'h40, 4'h2, '1);
        xfer(0, 8'h40, 4'hf, 0);
        `CHK("mask_byte", 32'h000fffc0, rd)
        standby_sleep_i <= 1'b1;
        period(0);
        `CHK("frozen", 300, p)
        clock_request_i <= 1'b1;
        period(0);
        `CHK("standby_run", 128, p)
        end_sim();
    end
endmodule : test_main_clock_divider_gating
`default_nettype wire
